// ==== logic/ivlw_core.sv ====
`timescale 1ns/100ps
`default_nettype none

// What this block does
// - all vectors and the start vector lie in words 0FFFFh down to 0FFC0h
// - start vector reading 0FFFFh puts the core straight into low_power_four
// - every reset cause goes through priority 31 and sets its own flag
// - pin nmi, oscillator fault, access violation share 0FFFCh, priority 30, no gie
// - timer channel zero at 0FFF2h; channel one and overflow share 0FFF0h
// - port 2 pin-change flags 6 and 7 share 0FFE6h, priority 19
// - eight port 1 pin-change flags share 0FFE4h, priority 18
// - an enabled nonmaskable event, or an enabled maskable one with gie set, wakes from any low-power mode and starts its handler
// - handler return restores the saved mode, which software may alter
// - run_state runs cpu with main, sub-main and auxiliary clocks
// - low_power_zero halts cpu and main clock; auxiliary and sub-main run
// - low_power_one as zero, dc generator off when oscillator unused in run
// - low_power_two stops main and sub-main; dc generator and aux clock stay
// - low_power_three stops main, sub-main and dc generator; aux clock runs
// - low_power_four stops all clocks, dc generator and crystal
// - priorities 15 to 0 are unused and may hold program code
// - individual enables suppress nonmaskable events; gie does not
// - fetch from 0h to 01FFh or any unused range resets the device
module ivlw_core
  import ivlw_pkg::*;
(
  // clock and reset
  input  wire logic        clk,
  input  wire logic        reset_n,
  // register port
  input  wire logic [2:0]  reg_addr,
  input  wire logic [15:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [15:0] reg_rdata,
  // peripheral events, one-cycle pulses on clk
  input  wire logic        wdt_expire,
  input  wire logic        osc_fault,
  input  wire logic        flash_acc_viol,
  input  wire logic        flash_key_viol,
  input  wire logic        cmp_event,
  input  wire logic        tmr_ch0_event,
  input  wire logic        tmr_ch1_event,
  input  wire logic        tmr_ovf_event,
  input  wire logic [7:0]  port1_events,
  input  wire logic [1:0]  port2_events,
  // reset / nmi pin, asynchronous
  input  wire logic        rst_nmi_pin_n,
  // cpu side
  input  wire logic        fetch_valid,
  input  wire logic [15:0] fetch_addr,
  input  wire logic        boot_vec_valid,
  input  wire logic [15:0] boot_vec,
  input  wire logic        irq_ack,
  input  wire logic        irq_return,
  output logic             irq_req,
  output logic      [15:0] irq_vector,
  output logic             sys_reset,
  output var ivlw_gate_t   clk_gates
);

  logic        pin_s1_q, pin_s2_q, pin_s3_q;
  logic [31:0] flag_q, flag_d, set_v, clr_v, en_q, live;
  ivlw_mode_t  mode_q, mode_d, sav_mode_q, sav_mode_d, eff_mode;
  logic        gie_q, gie_d, sav_gie_q, sav_gie_d;
  logic [2:0]  cfg_q;
  logic [4:0]  srv_q, sel_prio, vec_prio_d;
  logic        irq_req_q, irq_req_d, sys_reset_q;
  logic [15:0] irq_vec_q, rdata_q, rd_mux;
  ivlw_gate_t  gate_q, gate_d;

  // register decode
  wire wr_ctl   = reg_wr & (reg_addr == R_CTL);
  wire wr_saved = reg_wr & (reg_addr == R_SAVED);
  wire wr_ensys = reg_wr & (reg_addr == R_EN_SYS);
  wire wr_enprt = reg_wr & (reg_addr == R_EN_PORT);
  wire wr_fsys  = reg_wr & (reg_addr == R_FLG_SYS);
  wire wr_fprt  = reg_wr & (reg_addr == R_FLG_PORT);
  wire osc_idle = cfg_q[0];
  wire wdt_ivl  = cfg_q[1];
  wire pin_nmi  = cfg_q[2];

  // pin edge seen only after the second sync stage
  wire pin_fall = pin_s3_q & ~pin_s2_q;

  wire pc_bad = fetch_valid & ((fetch_addr <= REG_END)
              | ((fetch_addr > RAM_HI) & (fetch_addr < INFO_LO))
              | ((fetch_addr > INFO_HI) & (fetch_addr < CODE_LO)));

  wire reset_evt = (pin_fall & ~pin_nmi) | (wdt_expire & ~wdt_ivl)
                 | flash_key_viol | pc_bad;

  assign set_v = {port2_events, 6'h00, port1_events, 4'h0,
                  tmr_ovf_event, tmr_ch1_event, tmr_ch0_event, cmp_event,
                  pc_bad, flash_key_viol, flash_acc_viol, pin_fall & pin_nmi,
                  pin_fall & ~pin_nmi, 1'b0, osc_fault, wdt_expire};
  assign clr_v = {wr_fprt ? reg_wdata : 16'h0000, wr_fsys ? reg_wdata : 16'h0000};

  // set beats a same-cycle software clear
  genvar gi;
  for (gi = 0; gi < 32; gi++) begin : g_flag
    assign flag_d[gi] = set_v[gi] | (flag_q[gi] & ~clr_v[gi]);
  end

  assign live = flag_q & en_q;

  wire nmi_req = |(live & NMI_MASK);
  wire cmp_int = gie_q & live[B_CMP];
  wire wdt_int = gie_q & wdt_ivl & live[B_WDT];
  wire t0_int  = gie_q & live[B_TCH0];
  wire t1_int  = gie_q & (live[B_TCH1] | live[B_TOVF]);
  wire p2_int  = gie_q & (|live[B_P2+1:B_P2]);
  wire p1_int  = gie_q & (|live[B_P1+7:B_P1]);
  wire any_req = nmi_req | cmp_int | wdt_int | t0_int | t1_int | p2_int | p1_int;

  // nothing below priority 18 is ever chosen
  assign sel_prio = nmi_req ? P_NMI  :
                    cmp_int ? P_CMP  :
                    wdt_int ? P_WDT  :
                    t0_int  ? P_TCH0 :
                    t1_int  ? P_TCH1 :
                    p2_int  ? P_PORT2 : P_PORT1;

  wire ack_take = irq_ack & irq_req_q & ~reset_evt;
  assign irq_req_d  = any_req & ~ack_take & ~reset_evt;
  assign vec_prio_d = reset_evt ? P_RESET : sel_prio;

  wire boot_blank = boot_vec_valid & (boot_vec == BLANK_WORD);

  // mode sequencing: reset, accept, return, boot, software
  always_comb begin
    mode_d     = mode_q;
    gie_d      = gie_q;
    sav_mode_d = sav_mode_q;
    sav_gie_d  = sav_gie_q;
    if (reset_evt) begin
      mode_d = run_state;
      gie_d  = 1'b0;
    end else if (ack_take) begin
      sav_mode_d = mode_q;
      sav_gie_d  = gie_q;
      mode_d     = run_state;
      gie_d      = 1'b0;
    end else if (irq_return) begin
      mode_d = sav_mode_q;
      gie_d  = sav_gie_q;
    end else if (boot_blank) begin
      mode_d = low_power_four;
    end else if (wr_ctl) begin
      mode_d = ivlw_mode_t'(reg_wdata[2:0]);
      gie_d  = reg_wdata[3];
    end
    // software may rewrite the saved mode
    if (wr_saved && !ack_take && !reset_evt) begin
      sav_mode_d = ivlw_mode_t'(reg_wdata[2:0]);
      sav_gie_d  = reg_wdata[3];
    end
  end

  // pending request keeps clocks up so the cpu can accept it
  assign eff_mode = irq_req_d ? run_state : mode_d;

  always_comb begin
    case (eff_mode)
      run_state:       gate_d = GATE_RUN;
      low_power_zero:  gate_d = GATE_LP01;
      // dc generator off if unused in run
      low_power_one:   gate_d = osc_idle ? GATE_LP1I : GATE_LP01;
      // aux clock and dc generator stay
      low_power_two:   gate_d = GATE_LP2;
      low_power_three: gate_d = GATE_LP3;
      low_power_four:  gate_d = GATE_LP4;
      default:         gate_d = GATE_RUN;
    endcase
  end

  assign rd_mux = (reg_addr == R_CTL)      ? {9'h000, cfg_q, gie_q, mode_q} :
                  (reg_addr == R_SAVED)    ? {12'h000, sav_gie_q, sav_mode_q} :
                  (reg_addr == R_EN_SYS)   ? en_q[15:0] :
                  (reg_addr == R_EN_PORT)  ? en_q[31:16] :
                  (reg_addr == R_FLG_SYS)  ? flag_q[15:0] :
                  (reg_addr == R_FLG_PORT) ? flag_q[31:16] :
                  (reg_addr == R_STATUS)   ? {7'h00, irq_req_q, 3'h0, srv_q} :
                  16'h0000;

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      pin_s1_q <= 1'b1;
      pin_s2_q <= 1'b1;
      pin_s3_q <= 1'b1;
    end else begin
      pin_s1_q <= rst_nmi_pin_n;
      pin_s2_q <= pin_s1_q;
      pin_s3_q <= pin_s2_q;
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      // power-up flag set by power-on reset
      flag_q <= FLG_RESET;
      en_q   <= 32'h0000_0000;
      cfg_q  <= 3'h0;
    end else begin
      flag_q <= flag_d;
      if (reset_evt) begin
        en_q <= 32'h0000_0000;
      end else if (ack_take && sel_prio == P_NMI) begin
        // nmi enables drop on accept to block re-entry
        en_q <= en_q & ~NMI_MASK;
      end else begin
        en_q[15:0]  <= wr_ensys ? reg_wdata : en_q[15:0];
        en_q[31:16] <= wr_enprt ? reg_wdata : en_q[31:16];
      end
      cfg_q <= wr_ctl ? reg_wdata[6:4] : cfg_q;
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      mode_q     <= run_state;
      gie_q      <= 1'b0;
      sav_mode_q <= run_state;
      sav_gie_q  <= 1'b0;
      srv_q      <= 5'h00;
    end else begin
      mode_q     <= mode_d;
      gie_q      <= gie_d;
      sav_mode_q <= sav_mode_d;
      sav_gie_q  <= sav_gie_d;
      srv_q      <= ack_take ? irq_vec_q[5:1] : srv_q;
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      irq_req_q   <= 1'b0;
      sys_reset_q <= 1'b0;
      irq_vec_q   <= {VEC_PAGE, P_RESET, 1'b0};
      gate_q      <= GATE_RUN;
      rdata_q     <= 16'h0000;
    end else begin
      irq_req_q   <= irq_req_d;
      sys_reset_q <= reset_evt;
      // vector word in the top page
      irq_vec_q   <= {VEC_PAGE, vec_prio_d, 1'b0};
      gate_q      <= gate_d;
      rdata_q     <= reg_rd ? rd_mux : 16'h0000;
    end
  end

  assign reg_rdata  = rdata_q;
  assign irq_req    = irq_req_q;
  assign irq_vector = irq_vec_q;
  assign sys_reset  = sys_reset_q;
  assign clk_gates  = gate_q;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  vector_page_a: assert property (irq_vec_q[15:6] == 10'h3FF && !irq_vec_q[0])
    else $error("vector outside top page");
  boot_blank_a: assert property (boot_blank && !reset_evt && !ack_take && !irq_return
    |=> mode_q == low_power_four)
    else $error("blank start vector did not enter deepest mode");
  reset_vec_a: assert property (reset_evt |=> sys_reset_q && irq_vec_q == 16'hFFFE)
    else $error("reset cause without reset vector");
  pc_range_a: assert property (fetch_valid && fetch_addr <= 16'h01FF |=> sys_reset_q)
    else $error("fetch from register space did not reset");
  nmi_nogie_a: assert property (nmi_req && !gie_q && !reset_evt && !ack_take
    |=> irq_req_q && irq_vec_q == 16'hFFFC)
    else $error("nonmaskable request lost");
  prio_order_a: assert property (cmp_int && (t0_int || p2_int || p1_int) && !nmi_req
    && !reset_evt |=> irq_vec_q == 16'hFFF6)
    else $error("lower priority served first");
  slot_used_a: assert property (irq_req_q |-> irq_vec_q inside {16'hFFFC, 16'hFFF6,
    16'hFFF4, 16'hFFF2, 16'hFFF0, 16'hFFE6, 16'hFFE4})
    else $error("unassigned slot selected");
  wake_run_a: assert property (irq_req_q |-> clk_gates == GATE_RUN)
    else $error("pending request left cpu asleep");
  accept_drop_a: assert property (ack_take |=> !irq_req_q ##1 mode_q == run_state)
    else $error("accept did not end request");
  ret_restore_a: assert property (irq_return && !reset_evt && !ack_take
    |=> mode_q == $past(sav_mode_q))
    else $error("return did not restore mode");
  lp3_gates_a: assert property (mode_q == low_power_three && !irq_req_q
    |-> clk_gates == 6'h05)
    else $error("deep sleep gates wrong");
  lp4_gates_a: assert property (mode_q == low_power_four && !irq_req_q
    |-> clk_gates == 6'h00)
    else $error("stop mode left a clock running");
  lp0_gates_a: assert property (mode_q == low_power_zero && !irq_req_q
    |-> !clk_gates.mclk_en && clk_gates.sub_main_clock_en && clk_gates.aclk_en)
    else $error("light sleep gates wrong");

  handler_cycle_c: cover property (ack_take ##[1:20] irq_return);
  sleep_wake_c:    cover property (mode_q == low_power_three ##1 irq_req_q);
  reset_cause_c:   cover property (sys_reset_q);
  blank_boot_c:    cover property (boot_blank);

endmodule : ivlw_core
`default_nettype wire

// ==== pkg/ivlw_pkg.sv ====
`default_nettype none
package ivlw_pkg;

  // operating modes
  typedef enum logic [2:0] {
    run_state       = 3'b000,
    low_power_zero  = 3'b001,
    low_power_one   = 3'b010,
    low_power_two   = 3'b011,
    low_power_three = 3'b100,
    low_power_four  = 3'b101
  } ivlw_mode_t;

  // clock and oscillator gates, msb first
  typedef struct packed {
    logic cpu_run;
    logic mclk_en;
    logic sub_main_clock_en;
    logic aclk_en;
    logic dc_gen_en;
    logic xtal_en;
  } ivlw_gate_t;

  localparam ivlw_gate_t GATE_RUN  = 6'h3F;
  localparam ivlw_gate_t GATE_LP01 = 6'h0F;
  localparam ivlw_gate_t GATE_LP1I = 6'h0D;
  localparam ivlw_gate_t GATE_LP2  = 6'h07;
  localparam ivlw_gate_t GATE_LP3  = 6'h05;
  localparam ivlw_gate_t GATE_LP4  = 6'h00;

  // vector table: word address = {VEC_PAGE, priority, 0}
  localparam logic [9:0]  VEC_PAGE    = 10'h3FF;
  localparam logic [15:0] BLANK_WORD  = 16'hFFFF;
  localparam logic [4:0]  P_RESET     = 5'h1F;
  localparam logic [4:0]  P_NMI       = 5'h1E;
  localparam logic [4:0]  P_CMP       = 5'h1B;
  localparam logic [4:0]  P_WDT       = 5'h1A;
  localparam logic [4:0]  P_TCH0      = 5'h19;
  localparam logic [4:0]  P_TCH1      = 5'h18;
  localparam logic [4:0]  P_PORT2     = 5'h13;
  localparam logic [4:0]  P_PORT1     = 5'h12;

  // fetch map limits
  localparam logic [15:0] REG_END     = 16'h01FF;
  localparam logic [15:0] RAM_HI      = 16'h027F;
  localparam logic [15:0] INFO_LO     = 16'h1000;
  localparam logic [15:0] INFO_HI     = 16'h10FF;
  localparam logic [15:0] CODE_LO     = 16'hF800;

  // register indices
  localparam logic [2:0]  R_CTL       = 3'h0;
  localparam logic [2:0]  R_SAVED     = 3'h1;
  localparam logic [2:0]  R_EN_SYS    = 3'h2;
  localparam logic [2:0]  R_EN_PORT   = 3'h3;
  localparam logic [2:0]  R_FLG_SYS   = 3'h4;
  localparam logic [2:0]  R_FLG_PORT  = 3'h5;
  localparam logic [2:0]  R_STATUS    = 3'h6;

  // flag positions in the 32-bit flag word
  localparam int B_WDT   = 0;
  localparam int B_OSC   = 1;
  localparam int B_POR   = 2;
  localparam int B_EXT   = 3;
  localparam int B_NMI   = 4;
  localparam int B_ACC   = 5;
  localparam int B_KEY   = 6;
  localparam int B_PCR   = 7;
  localparam int B_CMP   = 8;
  localparam int B_TCH0  = 9;
  localparam int B_TCH1  = 10;
  localparam int B_TOVF  = 11;
  localparam int B_P1    = 16;
  localparam int B_P2    = 30;

  localparam logic [31:0] NMI_MASK    = 32'h0000_0032;
  localparam logic [31:0] FLG_RESET   = 32'h0000_0006;

endpackage : ivlw_pkg
`default_nettype wire

// ==== verif/interrupt_vectoring_lowpower_wake_tb.sv ====
`timescale 1ns/100ps
`default_nettype none
module interrupt_vectoring_lowpower_wake_tb
  import ivlw_pkg::*;
;
  logic        clk, reset_n, reg_wr, reg_rd, pin_n, fetch_valid, boot_valid;
  logic        irq_ack, irq_return, irq_req, sys_reset, rd_seen;
  logic [2:0]  reg_addr;
  logic [15:0] reg_wdata, reg_rdata, ev, fetch_addr, boot_word, irq_vector;
  logic [7:0]  p1_ev;
  logic [1:0]  p2_ev;
  logic [3:0]  ack_delay;
  ivlw_gate_t  gates;
  logic [15:0] rd_q[$];
  logic [15:0] vec_q[$];
  int          n_mismatch, checks, seed, bit_sel;
  ivlw_gate_t  gate_tab[6] = '{GATE_RUN, GATE_LP01, GATE_LP01, GATE_LP2, GATE_LP3, GATE_LP4};
  logic [15:0] ev_tab[5]   = '{16'h0001, 16'h0100, 16'h0200, 16'h0400, 16'h0800};
  logic [15:0] vec_tab[5]  = '{16'hFFF4, 16'hFFF6, 16'hFFF2, 16'hFFF0, 16'hFFF0};

  ivlw_core ivlw_core_inst (
    .clk(clk), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .wdt_expire(ev[0]),
    .osc_fault(ev[1]), .flash_acc_viol(ev[5]), .flash_key_viol(ev[6]), .cmp_event(ev[8]),
    .tmr_ch0_event(ev[9]), .tmr_ch1_event(ev[10]), .tmr_ovf_event(ev[11]),
    .port1_events(p1_ev), .port2_events(p2_ev), .rst_nmi_pin_n(pin_n),
    .fetch_valid(fetch_valid), .fetch_addr(fetch_addr), .boot_vec_valid(boot_valid),
    .boot_vec(boot_word), .irq_ack(irq_ack), .irq_return(irq_return), .irq_req(irq_req),
    .irq_vector(irq_vector), .sys_reset(sys_reset), .clk_gates(gates));

  ivlw_cpu_model ivlw_cpu_model_inst (
    .clk(clk), .reset_n(reset_n), .irq_req(irq_req), .ack_delay(ack_delay), .irq_ack(irq_ack));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic conclude();
    if (n_mismatch == 0 && checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : conclude

  // read data stands only in the cycle after the strobe
  always @(posedge clk) begin
    if (rd_seen && rd_q.size() > 0) check(reg_rdata, rd_q.pop_front());
    if (irq_ack === 1'b1 && vec_q.size() > 0) check(irq_vector, vec_q.pop_front());
    rd_seen <= reg_rd;
  end

  task automatic wr(input logic [2:0] a, input logic [15:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask : wr

  task automatic rd(input logic [2:0] a, input logic [15:0] exp);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    rd_q.push_back(exp);
    @(posedge clk);
    reg_rd <= 1'b0;
  endtask : rd

  task automatic pulse(input logic [15:0] e, input logic [7:0] a, input logic [1:0] b);
    @(posedge clk);
    ev <= e;
    p1_ev <= a;
    p2_ev <= b;
    @(posedge clk);
    ev <= 16'h0000;
    p1_ev <= 8'h00;
    p2_ev <= 2'b00;
  endtask : pulse

  task automatic strobe(input logic is_boot, input logic [15:0] w);
    @(posedge clk);
    boot_valid <= is_boot;
    fetch_valid <= !is_boot;
    fetch_addr <= w;
    boot_word <= w;
    @(posedge clk);
    boot_valid <= 1'b0;
    fetch_valid <= 1'b0;
  endtask : strobe

  task automatic ret();
    @(posedge clk);
    irq_return <= 1'b1;
    @(posedge clk);
    irq_return <= 1'b0;
  endtask : ret

  task automatic wait_ack();
    int n;
    n = 0;
    while (irq_ack !== 1'b1 && n < 60) begin
      @(posedge clk);
      n++;
    end
    check({15'h0000, irq_ack}, 16'h0001);
  endtask : wait_ack

  task automatic at(input int n);
    repeat (n) @(negedge clk);
  endtask : at

  initial begin
    {reset_n, reg_wr, reg_rd, fetch_valid, boot_valid, irq_return} = '0;
    {reg_addr, reg_wdata, ev, p1_ev, p2_ev, fetch_addr, boot_word, ack_delay} = '0;
    pin_n = 1'b1;
    n_mismatch = 0;
    checks = 0;
    seed = $urandom(32'h8c0f85d6);
    repeat (20) @(posedge clk);
    reset_n <= 1'b1;
    at(1);
    check(irq_vector, 16'hFFFE);
    check({10'h000, gates}, {10'h000, GATE_RUN});
    check({15'h0000, irq_req}, 16'h0000);
    rd(R_FLG_SYS, FLG_RESET);
    wr(3'h7, 16'hFFFF);
    rd(3'h7, 16'h0000);
    wr(R_EN_SYS, 16'h0002);
    vec_q.push_back(16'hFFFC);
    wait_ack();
    rd(R_EN_SYS, 16'h0000);
    wr(R_FLG_SYS, FLG_RESET);
    rd(R_FLG_SYS, 16'h0000);
    for (int m = 0; m < 6; m++) begin
      wr(R_CTL, 16'(m));
      at(2);
      check({10'h000, gates}, {10'h000, gate_tab[m]});
    end
    wr(R_CTL, 16'h0012);
    at(2);
    check({10'h000, gates}, {10'h000, GATE_LP1I});
    // single maskable sources, random cpu latency
    for (int i = 0; i < 5; i++) begin
      ack_delay <= 4'($urandom_range(0, 7));
      wr(R_EN_SYS, ev_tab[i]);
      wr(R_CTL, 16'h0028);
      vec_q.push_back(vec_tab[i]);
      pulse(ev_tab[i], 8'h00, 2'b00);
      wait_ack();
      wr(R_FLG_SYS, ev_tab[i]);
      ret();
    end
    bit_sel = $urandom_range(0, 7);
    ack_delay <= 4'h5;
    wr(R_EN_SYS, 16'h0100);
    wr(R_EN_PORT, 16'h8000 | (16'h0001 << bit_sel));
    wr(R_CTL, 16'h000C);
    at(2);
    check({10'h000, gates}, {10'h000, GATE_LP3});
    vec_q.push_back(16'hFFF6);
    vec_q.push_back(16'hFFE6);
    vec_q.push_back(16'hFFE4);
    pulse(16'h0100, 8'(1 << bit_sel), 2'b10);
    wait_ack();
    at(1);
    check({10'h000, gates}, {10'h000, GATE_RUN});
    wr(R_FLG_SYS, 16'h0100);
    ret();
    wait_ack();
    wr(R_FLG_PORT, 16'h8000);
    ret();
    wait_ack();
    rd(R_FLG_PORT, 16'h0001 << bit_sel);
    rd(R_STATUS, 16'h0012);
    wr(R_FLG_PORT, 16'h00FF);
    ret();
    at(2);
    check({10'h000, gates}, {10'h000, GATE_LP3});
    wr(R_CTL, 16'h0000);
    strobe(1'b0, CODE_LO);
    at(1);
    check({15'h0000, sys_reset}, 16'h0000);
    strobe(1'b0, 16'h0280 + 16'($urandom_range(0, 16'h0D7F)));
    at(1);
    check({15'h0000, sys_reset}, 16'h0001);
    check(irq_vector, 16'hFFFE);
    rd(R_FLG_SYS, 16'h0080);
    pulse(16'h0040, 8'h00, 2'b00);
    at(1);
    check({15'h0000, sys_reset}, 16'h0001);
    rd(R_FLG_SYS, 16'h00C0);
    strobe(1'b1, CODE_LO);
    at(1);
    check({10'h000, gates}, {10'h000, GATE_RUN});
    strobe(1'b1, BLANK_WORD);
    at(1);
    check({10'h000, gates}, {10'h000, GATE_LP4});
    // pin and watchdog as reset causes
    @(posedge clk);
    pin_n <= 1'b0;
    repeat (3) @(posedge clk);
    at(1);
    check({15'h0000, sys_reset}, 16'h0001);
    @(posedge clk);
    pin_n <= 1'b1;
    pulse(16'h0001, 8'h00, 2'b00);
    at(1);
    check({15'h0000, sys_reset}, 16'h0001);
    rd(R_FLG_SYS, 16'h00C9);
    // pin in nmi mode, then access fault behind its enable
    wr(R_FLG_SYS, 16'h00FF);
    wr(R_CTL, 16'h0040);
    wr(R_EN_SYS, 16'h0010);
    vec_q.push_back(16'hFFFC);
    @(posedge clk);
    pin_n <= 1'b0;
    wait_ack();
    pulse(16'h0020, 8'h00, 2'b00);
    at(2);
    check({15'h0000, irq_req}, 16'h0000);
    check({15'h0000, sys_reset}, 16'h0000);
    vec_q.push_back(16'hFFFC);
    wr(R_EN_SYS, 16'h0020);
    wait_ack();
    rd(R_FLG_SYS, 16'h0030);
    wr(R_SAVED, 16'h0003);
    ret();
    at(2);
    check({10'h000, gates}, {10'h000, GATE_LP2});
    at(3);
    conclude();
  end

  // whole sequence needs well under a thousand cycles
  initial begin
    #100000;
    n_mismatch++;
    conclude();
  end
endmodule : interrupt_vectoring_lowpower_wake_tb
`default_nettype wire

// ==== verif/ivlw_cpu_model.sv ====
`timescale 1ns/100ps
`default_nettype none
module ivlw_cpu_model (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       reset_n,
  // request side
  input  wire logic       irq_req,
  input  wire logic [3:0] ack_delay,
  output logic            irq_ack
);
  logic [3:0] wait_q;
  // a slow cpu finishes its instruction first; ack only while a request stands
  always_ff @(posedge clk) begin
    if (!reset_n || !irq_req || irq_ack) begin
      wait_q  <= 4'h0;
      irq_ack <= 1'b0;
    end else if (wait_q == ack_delay) begin
      irq_ack <= 1'b1;
    end else begin
      wait_q <= wait_q + 4'h1;
    end
  end
endmodule : ivlw_cpu_model
`default_nettype wire
